/* hdl/scsc_defs.svh */
// constants of the system clock source control block
`ifndef SCSC_DEFS_SVH
`define SCSC_DEFS_SVH
`define SCSC_ADDR_W 11
`define SCSC_OFS_RSVD_A 11'h400
`define SCSC_OFS_RSVD_B 11'h402
`define SCSC_OFS_RSVD_C 11'h404
`define SCSC_OFS_STRAP 11'h406
`define SCSC_OFS_OSC_A 11'h408
`define SCSC_OFS_OSC_B 11'h40A
`define SCSC_OFS_CFG_MAIN 11'h40C
`define SCSC_OFS_CFG_AUX 11'h40E
`define SCSC_OFS_SYN_CTL 11'h410
`define SCSC_OFS_SW_RESET 11'h412
`define SCSC_STRAP_W 9
`define SCSC_EN_BIT 0
`define SCSC_RST_CTL 16'h0000
`define SCSC_CFG_MASK 16'hFF3F
`define SCSC_LFR_HI 15
`define SCSC_LFR_LO 12
`define SCSC_VCB_HI 11
`define SCSC_VCB_LO 8
`define SCSC_VRS_HI 5
`define SCSC_VRS_LO 4
`define SCSC_FBF_HI 3
`define SCSC_FBF_LO 0
`define SCSC_ACK_LAT 2'h1
`endif

/* hdl/scsc_pkg.sv */
// types of the system clock source control block
package scsc_pkg;
	typedef enum logic [1:0] {SCSC_IDLE, SCSC_WAIT, SCSC_DONE} scsc_bus_e;
	typedef logic [15:0] scsc_word_t;
endpackage

/* hdl/scsc_ratio_dec.sv */
// decoder of vco ratio code and feedback factor
`timescale 1ns/1ps
`include "scsc_defs.svh"
module scsc_ratio_dec
	import scsc_pkg::*;
(
	input wire logic [1:0] ratio_code_i,
	input wire logic [3:0] feedback_field_i,
	output logic [3:0] vco_ratio_value_o,
	output logic ratio_reserved_o,
	output logic [4:0] feedback_factor_o
);
	always_comb
	begin
		case (ratio_code_i)
			2'h1: vco_ratio_value_o = 4'h2;
			2'h2: vco_ratio_value_o = 4'h4;
			2'h3: vco_ratio_value_o = 4'h8;
			default: vco_ratio_value_o = 4'h0;
		endcase
		ratio_reserved_o = (ratio_code_i == 2'h0);
		feedback_factor_o = {1'b0, feedback_field_i} + 5'h01;
	end
endmodule // scsc_ratio_dec

/* hdl/scsc_top.sv */
// register slave and outputs of the system clock source control block
`timescale 1ns/1ps
`include "scsc_defs.svh"
module scsc_top
	import scsc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [`SCSC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [1:0] avs_byteenable_i,
	input wire logic [15:0] avs_writedata_i,
	output logic [15:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	input wire logic [`SCSC_STRAP_W-1:0] config_strap_pins_i,
	output logic [`SCSC_STRAP_W-1:0] strap_latched_o,
	output logic oscillator_a_en_o,
	output logic oscillator_b_en_o,
	output logic synth_a_en_o,
	output logic synth_a_pwrdn_o,
	output logic [3:0] loop_filter_range_o,
	output logic [3:0] vco_band_select_o,
	output logic [3:0] vco_ratio_value_o,
	output logic vco_ratio_reserved_o,
	output logic [4:0] feedback_factor_o,
	output logic [15:0] synth_a_aux_o,
	output logic soft_reset_o
);
	// strap pins are asynchronous: two flops before any use
	logic [`SCSC_STRAP_W-1:0] strap_s1_ff, strap_s2_ff, nxt_strap_s1, nxt_strap_s2;
	logic [`SCSC_STRAP_W-1:0] strap_lat_ff, nxt_strap_lat;
	logic strap_taken_ff, nxt_strap_taken;

	always_comb
	begin
		nxt_strap_s1 = config_strap_pins_i;
		nxt_strap_s2 = strap_s1_ff;
	end

	// latch group: later pin changes reach only the status word, never this copy
	always_comb
	begin
		nxt_strap_lat = strap_lat_ff;
		nxt_strap_taken = 1'b1;
		// capture once, first clock after reset release
		if (!strap_taken_ff)
			nxt_strap_lat = strap_s2_ff;
	end

	always_ff @(posedge core_clk_i)
	begin
		strap_s1_ff <= nxt_strap_s1;
		strap_s2_ff <= nxt_strap_s2;
	end

	// synchroniser has no reset so the status word follows the pins during reset too
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			strap_lat_ff <= '0;
			strap_taken_ff <= 1'b0;
		end
		else
		begin
			strap_lat_ff <= nxt_strap_lat;
			strap_taken_ff <= nxt_strap_taken;
		end
	end

	// register file
	logic osc_a_ff, nxt_osc_a;
	logic osc_b_ff, nxt_osc_b;
	scsc_word_t cfg_main_ff, nxt_cfg_main;
	scsc_word_t cfg_aux_ff, nxt_cfg_aux;
	logic syn_en_ff, nxt_syn_en;
	logic soft_rst_ff, nxt_soft_rst;
	scsc_bus_e bus_ff, nxt_bus;
	scsc_word_t rdata_ff, nxt_rdata;
	logic [1:0] resp_ff, nxt_resp;
	logic wait_ff, nxt_wait;
	scsc_word_t wmask, rd_word;
	logic hit, do_write;

	always_comb
	begin
		wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		hit = 1'b1;
		rd_word = 16'h0000;
		case (avs_address_i)
			`SCSC_OFS_RSVD_A, `SCSC_OFS_RSVD_B, `SCSC_OFS_RSVD_C: rd_word = 16'h0000;
			`SCSC_OFS_STRAP: rd_word = {7'h00, strap_s2_ff};
			`SCSC_OFS_OSC_A: rd_word = {15'h0000, osc_a_ff};
			`SCSC_OFS_OSC_B: rd_word = {15'h0000, osc_b_ff};
			`SCSC_OFS_CFG_MAIN: rd_word = cfg_main_ff;
			`SCSC_OFS_CFG_AUX: rd_word = cfg_aux_ff;
			`SCSC_OFS_SYN_CTL: rd_word = {15'h0000, syn_en_ff};
			`SCSC_OFS_SW_RESET: rd_word = 16'h0000;
			default: hit = 1'b0;
		endcase
	end

	always_comb
	begin
		nxt_bus = bus_ff;
		nxt_rdata = rdata_ff;
		nxt_resp = resp_ff;
		nxt_wait = 1'b1;
		do_write = 1'b0;
		case (bus_ff)
			SCSC_IDLE:
				if (avs_read_i || avs_write_i)
				begin
					// one cycle to decode, then drop waitrequest for one cycle
					nxt_bus = SCSC_WAIT;
					nxt_rdata = avs_read_i ? rd_word : 16'h0000;
					nxt_resp = hit ? 2'h0 : 2'h3;
					nxt_wait = 1'b0;
					do_write = avs_write_i && hit;
				end
			SCSC_WAIT:
				nxt_bus = SCSC_DONE;
			SCSC_DONE:
				nxt_bus = SCSC_IDLE;
			default:
				nxt_bus = SCSC_IDLE;
		endcase
	end

	// register group commits at the taking edge; the answer follows one cycle later
	always_comb
	begin
		nxt_osc_a = osc_a_ff;
		nxt_osc_b = osc_b_ff;
		nxt_cfg_main = cfg_main_ff;
		nxt_cfg_aux = cfg_aux_ff;
		nxt_syn_en = syn_en_ff;
		nxt_soft_rst = 1'b0;
		if (do_write)
		begin
			case (avs_address_i)
				`SCSC_OFS_OSC_A:
					if (avs_byteenable_i[0])
						nxt_osc_a = avs_writedata_i[`SCSC_EN_BIT];
				`SCSC_OFS_OSC_B:
					if (avs_byteenable_i[0])
						nxt_osc_b = avs_writedata_i[`SCSC_EN_BIT];
				`SCSC_OFS_CFG_MAIN:
					// bits 7-6 stay zero
					nxt_cfg_main = ((cfg_main_ff & ~wmask) | (avs_writedata_i & wmask)) & `SCSC_CFG_MASK;
				`SCSC_OFS_CFG_AUX:
					nxt_cfg_aux = (cfg_aux_ff & ~wmask) | (avs_writedata_i & wmask);
				`SCSC_OFS_SYN_CTL:
					if (avs_byteenable_i[0])
						nxt_syn_en = avs_writedata_i[`SCSC_EN_BIT];
				`SCSC_OFS_SW_RESET:
					nxt_soft_rst = avs_byteenable_i[0] & avs_writedata_i[`SCSC_EN_BIT];
				default:
					nxt_soft_rst = 1'b0; // reserved words swallow writes
			endcase
		end
		// software reset clears synthesizer state but never the oscillators
		if (soft_rst_ff)
		begin
			nxt_cfg_main = `SCSC_RST_CTL;
			nxt_cfg_aux = `SCSC_RST_CTL;
			nxt_syn_en = 1'b0;
			nxt_osc_a = osc_a_ff;
			nxt_osc_b = osc_b_ff;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			bus_ff <= SCSC_IDLE;
			rdata_ff <= 16'h0000;
			resp_ff <= 2'h0;
			wait_ff <= 1'b1;
		end
		else
		begin
			bus_ff <= nxt_bus;
			rdata_ff <= nxt_rdata;
			resp_ff <= nxt_resp;
			wait_ff <= nxt_wait;
		end
	end

	// oscillator enables survive software reset; only reset_i or a write of 0 to their word clears them
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			osc_a_ff <= 1'b0;
			osc_b_ff <= 1'b0;
			cfg_main_ff <= `SCSC_RST_CTL;
			cfg_aux_ff <= `SCSC_RST_CTL;
			syn_en_ff <= 1'b0;
			soft_rst_ff <= 1'b0;
		end
		else
		begin
			osc_a_ff <= nxt_osc_a;
			osc_b_ff <= nxt_osc_b;
			cfg_main_ff <= nxt_cfg_main;
			cfg_aux_ff <= nxt_cfg_aux;
			syn_en_ff <= nxt_syn_en;
			soft_rst_ff <= nxt_soft_rst;
		end
	end

	logic [3:0] dec_ratio;
	logic dec_rsvd;
	logic [4:0] dec_factor;

	scsc_ratio_dec u_dec (
		.ratio_code_i(cfg_main_ff[`SCSC_VRS_HI:`SCSC_VRS_LO]),
		.feedback_field_i(cfg_main_ff[`SCSC_FBF_HI:`SCSC_FBF_LO]),
		.vco_ratio_value_o(dec_ratio),
		.ratio_reserved_o(dec_rsvd),
		.feedback_factor_o(dec_factor)
	);

	// output stage registered so every port leaves a flop
	logic [`SCSC_STRAP_W-1:0] o_strap_ff;
	logic [`SCSC_STRAP_W-1:0] nxt_o_strap;
	logic o_osc_a_ff;
	logic nxt_o_osc_a;
	logic o_osc_b_ff;
	logic nxt_o_osc_b;
	logic o_syn_ff;
	logic nxt_o_syn;
	logic o_pwrdn_ff;
	logic nxt_o_pwrdn;
	logic o_soft_ff;
	logic nxt_o_soft;
	logic o_rsvd_ff;
	logic nxt_o_rsvd;
	logic [3:0] o_lfr_ff;
	logic [3:0] nxt_o_lfr;
	logic [3:0] o_vcb_ff;
	logic [3:0] nxt_o_vcb;
	logic [3:0] o_ratio_ff;
	logic [3:0] nxt_o_ratio;
	logic [4:0] o_fac_ff;
	logic [4:0] nxt_o_fac;
	scsc_word_t o_aux_ff;
	scsc_word_t nxt_o_aux;

	always_comb
	begin
		nxt_o_strap = strap_lat_ff;
		nxt_o_osc_a = osc_a_ff;
		nxt_o_osc_b = osc_b_ff;
		nxt_o_syn = syn_en_ff;
		// power down has its own flop so the pin stays glitch-free
		nxt_o_pwrdn = ~syn_en_ff;
		nxt_o_soft = soft_rst_ff;
		nxt_o_rsvd = dec_rsvd;
		nxt_o_lfr = cfg_main_ff[`SCSC_LFR_HI:`SCSC_LFR_LO];
		nxt_o_vcb = cfg_main_ff[`SCSC_VCB_HI:`SCSC_VCB_LO];
		nxt_o_ratio = dec_ratio;
		nxt_o_fac = dec_factor;
		nxt_o_aux = cfg_aux_ff;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			o_strap_ff <= '0;
			o_osc_a_ff <= 1'b0;
			o_osc_b_ff <= 1'b0;
			o_syn_ff <= 1'b0;
			// a disabled synthesizer is powered down, during reset as well
			o_pwrdn_ff <= 1'b1;
			o_soft_ff <= 1'b0;
			o_rsvd_ff <= 1'b0;
			o_lfr_ff <= 4'h0;
			o_vcb_ff <= 4'h0;
			o_ratio_ff <= 4'h0;
			o_fac_ff <= 5'h00;
			o_aux_ff <= 16'h0000;
		end
		else
		begin
			o_strap_ff <= nxt_o_strap;
			o_osc_a_ff <= nxt_o_osc_a;
			o_osc_b_ff <= nxt_o_osc_b;
			o_syn_ff <= nxt_o_syn;
			o_pwrdn_ff <= nxt_o_pwrdn;
			o_soft_ff <= nxt_o_soft;
			o_rsvd_ff <= nxt_o_rsvd;
			o_lfr_ff <= nxt_o_lfr;
			o_vcb_ff <= nxt_o_vcb;
			o_ratio_ff <= nxt_o_ratio;
			o_fac_ff <= nxt_o_fac;
			o_aux_ff <= nxt_o_aux;
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	assign avs_response_o = resp_ff;
	assign strap_latched_o = o_strap_ff;
	assign oscillator_a_en_o = o_osc_a_ff;
	assign oscillator_b_en_o = o_osc_b_ff;
	assign synth_a_en_o = o_syn_ff;
	assign synth_a_pwrdn_o = o_pwrdn_ff;
	assign loop_filter_range_o = o_lfr_ff;
	assign vco_band_select_o = o_vcb_ff;
	assign vco_ratio_value_o = o_ratio_ff;
	assign vco_ratio_reserved_o = o_rsvd_ff;
	assign feedback_factor_o = o_fac_ff;
	assign synth_a_aux_o = o_aux_ff;
	assign soft_reset_o = o_soft_ff;
endmodule // scsc_top

/* tb/scsc_top_checker.sv */
// assertion checker of the clock source control block
`timescale 1ns/1ps
`include "scsc_defs.svh"
module scsc_checker
	import scsc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [`SCSC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_write_i,
	input wire logic [1:0] avs_byteenable_i,
	input wire logic [15:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	input wire logic [`SCSC_STRAP_W-1:0] strap_latched_o,
	input wire logic oscillator_a_en_o,
	input wire logic oscillator_b_en_o,
	input wire logic synth_a_en_o,
	input wire logic synth_a_pwrdn_o,
	input wire logic [3:0] vco_ratio_value_o,
	input wire logic vco_ratio_reserved_o,
	input wire logic [4:0] feedback_factor_o,
	input wire logic soft_reset_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	logic wr_ok;
	logic [2:0] age_ff;
	// outputs lag the registers, so settled checks wait three edges past reset
	always_ff @(posedge core_clk_i) age_ff <= reset_i ? 3'h0 : {age_ff[1:0], 1'b1};
	assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	a_osc_a_follow: assert property (wr_ok && avs_address_i == 11'h408 |=> oscillator_a_en_o == $past(avs_writedata_i[0]))
		else $error("oscillator_a enable differs from written bit");
	a_osc_b_follow: assert property (wr_ok && avs_address_i == 11'h40A |=> oscillator_b_en_o == $past(avs_writedata_i[0]))
		else $error("oscillator_b enable differs from written bit");
	a_synth_en_follow: assert property (wr_ok && avs_address_i == 11'h410 |=> synth_a_en_o == $past(avs_writedata_i[0]))
		else $error("synthesizer enable differs from written bit");
	a_pwrdn_inverse: assert property (age_ff[2] |-> synth_a_pwrdn_o != synth_a_en_o)
		else $error("power down is not the inverse of enable");
	a_fbf_plus_one: assert property (wr_ok && avs_address_i == 11'h40C |=> feedback_factor_o == $past(avs_writedata_i[3:0]) + 5'h01)
		else $error("feedback factor is not field plus one");
	a_ratio_code: assert property (wr_ok && avs_address_i == 11'h40C |=> vco_ratio_reserved_o == ($past(avs_writedata_i[5:4]) == 2'h0))
		else $error("reserved ratio flag wrong");
	a_ratio_value: assert property (age_ff[2] && !vco_ratio_reserved_o |-> vco_ratio_value_o inside {4'h2, 4'h4, 4'h8})
		else $error("ratio value not 2, 4 or 8");
	a_strap_hold: assert property (age_ff[2] |-> $stable(strap_latched_o))
		else $error("latched straps changed after reset release");
	a_soft_keeps_osc: assert property (soft_reset_o |=> $stable(oscillator_a_en_o) && $stable(oscillator_b_en_o))
		else $error("software reset touched an oscillator enable");
	c_soft_reset: cover property (soft_reset_o);
	c_cfg_write: cover property (wr_ok && avs_address_i == 11'h40C);
	c_both_osc: cover property (oscillator_a_en_o && oscillator_b_en_o);
endmodule // scsc_checker
bind scsc_top scsc_checker u_chk (
	.core_clk_i(core_clk_i),
	.reset_i(reset_i),
	.avs_address_i(avs_address_i),
	.avs_write_i(avs_write_i),
	.avs_byteenable_i(avs_byteenable_i),
	.avs_writedata_i(avs_writedata_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.strap_latched_o(strap_latched_o),
	.oscillator_a_en_o(oscillator_a_en_o),
	.oscillator_b_en_o(oscillator_b_en_o),
	.synth_a_en_o(synth_a_en_o),
	.synth_a_pwrdn_o(synth_a_pwrdn_o),
	.vco_ratio_value_o(vco_ratio_value_o),
	.vco_ratio_reserved_o(vco_ratio_reserved_o),
	.feedback_factor_o(feedback_factor_o),
	.soft_reset_o(soft_reset_o)
);

/* tb/scsc_top_test.sv */
// self-checking bench of the clock source control block
`timescale 1ns/1ps
`include "scsc_defs.svh"
module scsc_top_test
	import scsc_pkg::*;
();
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [`SCSC_ADDR_W-1:0] avs_address_i = 11'h000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [1:0] avs_byteenable_i = 2'h3;
	scsc_word_t avs_writedata_i = 16'h0000;
	logic [`SCSC_STRAP_W-1:0] config_strap_pins_i = 9'h1A5;
	logic avs_waitrequest_o, oscillator_a_en_o, oscillator_b_en_o, synth_a_en_o, synth_a_pwrdn_o;
	logic vco_ratio_reserved_o, soft_reset_o;
	logic [1:0] avs_response_o, rs;
	logic [`SCSC_STRAP_W-1:0] strap_latched_o;
	logic [3:0] loop_filter_range_o, vco_band_select_o, vco_ratio_value_o;
	logic [4:0] feedback_factor_o;
	scsc_word_t avs_readdata_o, synth_a_aux_o, rd;
	int err_count = 0;
	int checked = 0;
	typedef struct {logic [10:0] a; scsc_word_t d; scsc_word_t e;} scsc_row_s;
	scsc_row_s rows [7] = '{
		'{11'h408, 16'hFFFF, 16'h0001},
		'{11'h40A, 16'hFFFF, 16'h0001},
		'{11'h40C, 16'hA2E3, 16'hA223},
		'{11'h40C, 16'h8311, 16'h8311},
		'{11'h40E, 16'h0040, 16'h0040},
		'{11'h410, 16'hFFFF, 16'h0001},
		'{11'h7FE, 16'hFFFF, 16'h0000}};
	logic [3:0] rv [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
	logic [10:0] rst_list [8] = '{11'h400, 11'h402, 11'h404, 11'h408, 11'h40A, 11'h40C, 11'h40E, 11'h410};
	scsc_top uut (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.avs_response_o(avs_response_o),
		.config_strap_pins_i(config_strap_pins_i),
		.strap_latched_o(strap_latched_o),
		.oscillator_a_en_o(oscillator_a_en_o),
		.oscillator_b_en_o(oscillator_b_en_o),
		.synth_a_en_o(synth_a_en_o),
		.synth_a_pwrdn_o(synth_a_pwrdn_o),
		.loop_filter_range_o(loop_filter_range_o),
		.vco_band_select_o(vco_band_select_o),
		.vco_ratio_value_o(vco_ratio_value_o),
		.vco_ratio_reserved_o(vco_ratio_reserved_o),
		.feedback_factor_o(feedback_factor_o),
		.synth_a_aux_o(synth_a_aux_o),
		.soft_reset_o(soft_reset_o)
	);
	always #4 core_clk_i = ~core_clk_i;
	task automatic report_and_stop();
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input scsc_word_t exp, input scsc_word_t got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [10:0] a, input scsc_word_t d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do
			@(posedge core_clk_i);
		while (avs_waitrequest_o !== 1'b0 && ++n < 40);
		rd = avs_readdata_o;
		rs = avs_response_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 40)
		begin
			err_count++;
			report_and_stop();
		end
	endtask
	initial
	begin
		// two edges of reset fill the strap synchroniser before capture
		repeat (2) @(posedge core_clk_i);
		reset_i <= 1'b0;
		config_strap_pins_i <= 9'h05A;
		repeat (4) @(posedge core_clk_i);
		bus(0, 11'h406, 16'h0000);
		chk("strap status", 16'h005A, rd);
		chk("strap latch", 16'h01A5, {7'h00, strap_latched_o});
		foreach (rows[i])
		begin
			bus(1, rows[i].a, rows[i].d);
			if (rows[i].a == `SCSC_OFS_OSC_A || rows[i].a == `SCSC_OFS_OSC_B)
				repeat (16) @(posedge core_clk_i);
			bus(0, rows[i].a, 16'h0000);
			chk("readback", rows[i].e, rd);
		end
		chk("unmapped response", 16'h0003, {14'h0000, rs});
		chk("synth fields", 16'h8322, {loop_filter_range_o, vco_band_select_o, vco_ratio_value_o, feedback_factor_o[3:0]});
		chk("enables", 16'h000E, {12'h000, oscillator_a_en_o, oscillator_b_en_o, synth_a_en_o, synth_a_pwrdn_o});
		bus(1, 11'h410, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, 11'h40C, {10'h20C, i[1:0], 4'h1});
			@(negedge core_clk_i);
			chk("ratio", {11'h000, i == 0, rv[i]}, {11'h000, vco_ratio_reserved_o, vco_ratio_value_o});
		end
		chk("enables off", 16'h000D, {12'h000, oscillator_a_en_o, oscillator_b_en_o, synth_a_en_o, synth_a_pwrdn_o});
		bus(1, `SCSC_OFS_SW_RESET, 16'h0001);
		@(negedge core_clk_i);
		chk("soft reset pulse", 16'h0001, {15'h0000, soft_reset_o});
		bus(0, 11'h408, 16'h0000);
		chk("osc_a kept", 16'h0001, rd);
		bus(0, 11'h40A, 16'h0000);
		chk("osc_b kept", 16'h0001, rd);
		bus(0, 11'h40C, 16'h0000);
		chk("config cleared", 16'h0000, rd);
		avs_byteenable_i <= 2'h1;
		bus(1, `SCSC_OFS_CFG_AUX, 16'h1240);
		avs_byteenable_i <= 2'h3;
		bus(0, `SCSC_OFS_CFG_AUX, 16'h0000);
		chk("lane write", 16'h0040, rd);
		chk("aux output", 16'h0040, synth_a_aux_o);
		// software never stops an oscillator here, so no panel sequencing is owed
		reset_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		reset_i <= 1'b0;
		foreach (rst_list[i])
		begin
			bus(0, rst_list[i], 16'h0000);
			chk("reset value", 16'h0000, rd);
		end
		report_and_stop();
	end
endmodule // scsc_top_test
